// ==== verilog/irr_pkg.sv ====
// constants shared by the inductive result readout block
package irr_pkg;
   // register addresses (7-bit spi address space)
   localparam logic [6:0] IRR_ADDR_CEILING  = 7'h01;
   localparam logic [6:0] IRR_ADDR_FLOOR    = 7'h02;
   localparam logic [6:0] IRR_ADDR_CONFIG   = 7'h04;
   localparam logic [6:0] IRR_ADDR_POWER    = 7'h0b;
   localparam logic [6:0] IRR_ADDR_STATUS   = 7'h20;
   localparam logic [6:0] IRR_ADDR_PROX_LO  = 7'h21;
   localparam logic [6:0] IRR_ADDR_PROX_HI  = 7'h22;
   localparam logic [6:0] IRR_ADDR_FREQ_LO  = 7'h23;
   localparam logic [6:0] IRR_ADDR_FREQ_MID = 7'h24;
   localparam logic [6:0] IRR_ADDR_FREQ_HI  = 7'h25;
   // reset values
   localparam logic [7:0] IRR_RST_CEILING   = 8'h0e;
   localparam logic [7:0] IRR_RST_FLOOR     = 8'h14;
   localparam logic [7:0] IRR_RST_CONFIG    = 8'h00;
   localparam logic [7:0] IRR_RST_POWER     = 8'h00;
   // field positions
   localparam int         IRR_POWER_EN_BIT  = 0;
   localparam int         IRR_STATUS_RDY_BIT = 6;
   localparam int         IRR_SPI_RW_BIT    = 7;
   // response time: code 2 -> 192 oscillator periods, doubling per code
   localparam logic [2:0]  IRR_RESP_CODE_MIN = 3'h2;
   localparam logic [15:0] IRR_RESP_BASE     = 16'h00c0;
   localparam logic [15:0] IRR_RESP_DIVISOR  = 16'h0003;
   localparam logic [23:0] IRR_FREQ_MAX      = 24'hffffff;
   // range code to 16-bit impedance limit
   localparam logic [10:0] IRR_LIMIT_FILL    = 11'h7ff;
endpackage

// ==== verilog/irr_reg_if.sv ====
// register access carrier between the spi front end and the result bank
`timescale 1ns/1ps
`default_nettype none
interface irr_reg_if;
   logic       rd_req;
   logic       wr_stb;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport spi  (output rd_req, output wr_stb, output addr, output wdata, input rdata);
   modport regs (input rd_req, input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== verilog/irr_spi_port.sv ====
// spi slave front end: pin synchronisers, byte framing, address auto-increment
`timescale 1ns/1ps
`default_nettype none
module irr_spi_port
   import irr_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic spi_sclk,
   input  wire logic spi_cs_n,
   input  wire logic spi_sdi,
   output logic      spi_sdo,
   output logic      spi_sdo_oe,
   irr_reg_if.spi    bus
);
   logic [2:0] sclk_s, cs_s, sdi_s;
   logic       sclk_f, cs_f, next_sclk_f, next_cs_f;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [6:0] shin, next_shin;
   logic [7:0] shout, next_shout, wdata, next_wdata;
   logic [6:0] addr, next_addr;
   logic       first, next_first, rw, next_rw, fresh, next_fresh;
   logic       rd_req, next_rd_req, wr_stb, next_wr_stb, load;
   logic       next_sdo, next_sdo_oe, rise, fall;
   logic [7:0] byte_in;

   assign bus.rd_req = rd_req;
   assign bus.wr_stb = wr_stb;
   assign bus.addr   = addr;
   assign bus.wdata  = wdata;

   always_comb begin
      // a pin change counts only once stages two and three agree
      next_sclk_f  = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_f;
      next_cs_f    = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_f;
      rise         = next_sclk_f & ~sclk_f;
      fall         = ~next_sclk_f & sclk_f;
      byte_in      = {shin, sdi_s[2]};
      next_bit_cnt = bit_cnt;
      next_shin    = shin;
      next_shout   = shout;
      next_wdata   = wdata;
      next_addr    = addr;
      next_first   = first;
      next_rw      = rw;
      next_fresh   = fresh;
      next_rd_req  = 1'b0;
      next_wr_stb  = 1'b0;
      if (wr_stb) begin
         next_addr = addr + 7'h01;
      end
      if (load) begin
         next_shout = bus.rdata;
         next_fresh = 1'b1;
      end
      if (next_cs_f) begin
         next_bit_cnt = 3'h0;
         next_first   = 1'b1;
         next_rw      = 1'b0;
      end else begin
         if (rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            next_shin    = byte_in[6:0];
            if (bit_cnt == 3'h7) begin
               if (first) begin
                  next_first  = 1'b0;
                  next_rw     = byte_in[IRR_SPI_RW_BIT];
                  next_addr   = byte_in[6:0];
                  next_rd_req = byte_in[IRR_SPI_RW_BIT];
               end else if (rw) begin
                  next_addr   = addr + 7'h01;
                  next_rd_req = 1'b1;
               end else begin
                  next_wdata  = byte_in;
                  next_wr_stb = 1'b1;
               end
            end
         end
         // the first falling edge after a load presents bit 7, so it must not shift;
         // a load landing on a falling edge wins, so the fresh byte is never shifted
         if (fall && !load) begin
            if (fresh) begin
               next_fresh = 1'b0;
            end else begin
               next_shout = {shout[6:0], 1'b0};
            end
         end
      end
      next_sdo    = next_shout[7];
      next_sdo_oe = ~next_cs_f & next_rw & ~next_first;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclk_s     <= 3'h0;
         cs_s       <= 3'h7;
         sdi_s      <= 3'h0;
         sclk_f     <= 1'b0;
         cs_f       <= 1'b1;
         bit_cnt    <= 3'h0;
         shin       <= 7'h00;
         shout      <= 8'h00;
         wdata      <= 8'h00;
         addr       <= 7'h00;
         first      <= 1'b1;
         rw         <= 1'b0;
         fresh      <= 1'b0;
         rd_req     <= 1'b0;
         wr_stb     <= 1'b0;
         load       <= 1'b0;
         spi_sdo    <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else begin
         sclk_s     <= {sclk_s[1:0], spi_sclk};
         cs_s       <= {cs_s[1:0], spi_cs_n};
         sdi_s      <= {sdi_s[1:0], spi_sdi};
         sclk_f     <= next_sclk_f;
         cs_f       <= next_cs_f;
         bit_cnt    <= next_bit_cnt;
         shin       <= next_shin;
         shout      <= next_shout;
         wdata      <= next_wdata;
         addr       <= next_addr;
         first      <= next_first;
         rw         <= next_rw;
         fresh      <= next_fresh;
         rd_req     <= next_rd_req;
         wr_stb     <= next_wr_stb;
         load       <= rd_req;
         spi_sdo    <= next_sdo;
         spi_sdo_oe <= next_sdo_oe;
      end
   end
endmodule // irr_spi_port
`default_nettype wire

// ==== verilog/irr_readout.sv ====
// result bank, configuration registers and sample engine of the inductive readout
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - proximity 16-bit read-only at 0x21, 0x22
// RULE2 - frequency count bytes at 0x23, 0x24, 0x25
// RULE3 - snapshot taken only when read of 0x21 begins
// RULE4 - snapshot held until next 0x21 read
// RULE5 - host starts every result read at 0x21
// RULE6 - sample rate is oscillator over response/3
// RULE7 - impedance clipped to floor and ceiling limits
// RULE8 - range floor resets to 0x14
// RULE9 - host writes only defined range codes
// RULE10 - status bit 6 flags new data
// RULE11 - convert only while power bit 0 set
// RULE12 - reads of 0x22..0x25 never refresh snapshot
module irr_readout
   import irr_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   output logic             spi_sdo_oe,
   input  wire logic        sensor_osc,
   input  wire logic [15:0] impedance_raw
);
   import irr_pkg::*;

   // ****************************************************************
   // spi front end
   // ****************************************************************
   irr_reg_if bus ();

   irr_spi_port irr_spi_port_i (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .spi_sclk   (spi_sclk),
      .spi_cs_n   (spi_cs_n),
      .spi_sdi    (spi_sdi),
      .spi_sdo    (spi_sdo),
      .spi_sdo_oe (spi_sdo_oe),
      .bus        (bus)
   );

   function automatic logic [15:0] range_limit(input logic [7:0] code, input logic top);
      // larger codes stand for lower impedance, so the limit falls as the code rises
      range_limit = {~code[4:0], top ? IRR_LIMIT_FILL : 11'h000};
   endfunction

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [7:0] range_ceiling, range_floor, sensor_cfg, power_cfg;
   logic [7:0] next_ceiling, next_floor, next_cfg, next_power;
   logic       conv_en;

   always_comb begin
      next_ceiling = range_ceiling;
      next_floor   = range_floor;
      next_cfg     = sensor_cfg;
      next_power   = power_cfg;
      if (bus.wr_stb) begin
         unique case (bus.addr)
            IRR_ADDR_CEILING: next_ceiling = bus.wdata;
            IRR_ADDR_FLOOR:   next_floor   = bus.wdata;
            IRR_ADDR_CONFIG:  next_cfg     = bus.wdata;
            IRR_ADDR_POWER:   next_power   = {7'h00, bus.wdata[IRR_POWER_EN_BIT]};
            default:          next_power   = power_cfg;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         range_ceiling <= IRR_RST_CEILING;
         range_floor   <= IRR_RST_FLOOR; // [RULE8]
         sensor_cfg    <= IRR_RST_CONFIG;
         power_cfg     <= IRR_RST_POWER;
      end else begin
         range_ceiling <= next_ceiling;
         range_floor   <= next_floor;
         sensor_cfg    <= next_cfg;
         power_cfg     <= next_power;
      end
   end

   assign conv_en = power_cfg[IRR_POWER_EN_BIT]; // [RULE11]

   // ****************************************************************
   // sample engine
   // ****************************************************************
   logic [2:0]  osc_s;
   logic        osc_f, next_osc_f, osc_rise;
   logic [15:0] edge_cnt, next_edge_cnt, divisor;
   logic [23:0] clk_cnt, next_clk_cnt, latest_freq, next_latest_freq;
   logic [15:0] latest_prox, next_latest_prox, floor_lim, ceil_lim;
   logic        sample_done, next_sample_done;
   logic [2:0]  resp_code;

   always_comb begin
      next_osc_f = (osc_s[1] == osc_s[2]) ? osc_s[2] : osc_f;
      osc_rise   = next_osc_f & ~osc_f;
      // reserved response codes run at the shortest setting
      resp_code  = (sensor_cfg[2:0] < IRR_RESP_CODE_MIN) ? IRR_RESP_CODE_MIN : sensor_cfg[2:0];
      divisor    = (IRR_RESP_BASE << (resp_code - IRR_RESP_CODE_MIN)) / IRR_RESP_DIVISOR;
      floor_lim  = range_limit(range_floor, 1'b0);
      ceil_lim   = range_limit(range_ceiling, 1'b1);
      next_edge_cnt    = edge_cnt;
      next_clk_cnt     = (clk_cnt == IRR_FREQ_MAX) ? clk_cnt : clk_cnt + 24'h000001;
      next_latest_freq = latest_freq;
      next_latest_prox = latest_prox;
      next_sample_done = 1'b0;
      if (!conv_en) begin // [RULE11]
         next_edge_cnt = 16'h0000;
         next_clk_cnt  = 24'h000000;
      end else if (osc_rise) begin
         if (edge_cnt >= divisor - 16'h0001) begin // [RULE6]
            // take the count including this cycle before the counter restarts
            next_latest_freq = next_clk_cnt;
            next_edge_cnt    = 16'h0000;
            next_clk_cnt     = 24'h000000;
            next_sample_done = 1'b1;
            if (impedance_raw > ceil_lim) begin // [RULE7]
               next_latest_prox = ceil_lim;
            end else if (impedance_raw < floor_lim) begin
               next_latest_prox = floor_lim;
            end else begin
               next_latest_prox = impedance_raw;
            end
         end else begin
            next_edge_cnt = edge_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osc_s       <= 3'h0;
         osc_f       <= 1'b0;
         edge_cnt    <= 16'h0000;
         clk_cnt     <= 24'h000000;
         latest_freq <= 24'h000000;
         latest_prox <= 16'h0000;
         sample_done <= 1'b0;
      end else begin
         osc_s       <= {osc_s[1:0], sensor_osc};
         osc_f       <= next_osc_f;
         edge_cnt    <= next_edge_cnt;
         clk_cnt     <= next_clk_cnt;
         latest_freq <= next_latest_freq;
         latest_prox <= next_latest_prox;
         sample_done <= next_sample_done;
      end
   end

   // ****************************************************************
   // result snapshot, status and read mux
   // ****************************************************************
   logic [15:0] prox_snap, next_prox_snap;
   logic [23:0] freq_snap, next_freq_snap;
   logic        data_ready, next_data_ready, capture;
   logic [7:0]  rdata, next_rdata;

   assign bus.rdata = rdata;

   always_comb begin
      // the host must open each result sequence here to get one coherent set [RULE5]
      capture         = bus.rd_req && (bus.addr == IRR_ADDR_PROX_LO); // [RULE3] [RULE12]
      next_prox_snap  = capture ? latest_prox : prox_snap; // [RULE4]
      next_freq_snap  = capture ? latest_freq : freq_snap;
      // a sample landing in the capture cycle keeps the flag set
      next_data_ready = sample_done | (data_ready & ~capture); // [RULE10]
      next_rdata      = rdata;
      if (bus.rd_req) begin
         unique case (bus.addr)
            IRR_ADDR_CEILING:  next_rdata = range_ceiling;
            IRR_ADDR_FLOOR:    next_rdata = range_floor;
            IRR_ADDR_CONFIG:   next_rdata = sensor_cfg;
            IRR_ADDR_POWER:    next_rdata = power_cfg;
            // ready reads as 0, matching the active-low ready pin convention
            IRR_ADDR_STATUS: begin
               next_rdata                     = 8'h00;
               next_rdata[IRR_STATUS_RDY_BIT] = ~data_ready; // [RULE10]
            end
            IRR_ADDR_PROX_LO:  next_rdata = next_prox_snap[7:0]; // [RULE1]
            IRR_ADDR_PROX_HI:  next_rdata = prox_snap[15:8];
            IRR_ADDR_FREQ_LO:  next_rdata = freq_snap[7:0]; // [RULE2]
            IRR_ADDR_FREQ_MID: next_rdata = freq_snap[15:8];
            IRR_ADDR_FREQ_HI:  next_rdata = freq_snap[23:16];
            default:           next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prox_snap  <= 16'h0000;
         freq_snap  <= 24'h000000;
         data_ready <= 1'b0;
         rdata      <= 8'h00;
      end else begin
         prox_snap  <= next_prox_snap;
         freq_snap  <= next_freq_snap;
         data_ready <= next_data_ready;
         rdata      <= next_rdata;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   AST_CAPTURE_VALUE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3]
      capture |=> (prox_snap == $past(latest_prox)) && (freq_snap == $past(latest_freq)))
      else $error("snapshot did not take the latest conversion");
   AST_HOLD_SNAPSHOT: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
      !capture |=> $stable(prox_snap) && $stable(freq_snap))
      else $error("snapshot changed without a read of the low proximity byte");
   AST_NO_REFRESH: assert property (@(posedge sys_clk) disable iff (rst) // [RULE12]
      bus.rd_req && (bus.addr > IRR_ADDR_PROX_LO) && (bus.addr <= IRR_ADDR_FREQ_HI)
      |=> $stable(prox_snap) && $stable(freq_snap))
      else $error("upper result read refreshed the snapshot");
   AST_PROX_LOW_READ: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
      bus.rd_req && (bus.addr == IRR_ADDR_PROX_LO) |=> rdata == $past(latest_prox[7:0]))
      else $error("low proximity byte wrong");
   AST_FREQ_HIGH_READ: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
      bus.rd_req && (bus.addr == IRR_ADDR_FREQ_HI) |=> rdata == freq_snap[23:16])
      else $error("high frequency byte wrong");
   AST_STANDBY: assert property (@(posedge sys_clk) disable iff (rst) // [RULE11]
      !conv_en |=> !sample_done)
      else $error("sample produced in standby");
   AST_RATE: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
      conv_en && osc_rise && (edge_cnt == divisor - 16'h0001) |=> sample_done ##1 !sample_done)
      else $error("sample not produced at the response interval");
   AST_CLIP: assert property (@(posedge sys_clk) disable iff (rst) // [RULE7]
      sample_done && (floor_lim <= ceil_lim)
      |-> (latest_prox <= ceil_lim) && (latest_prox >= floor_lim))
      else $error("proximity result outside range limits");
   AST_FLOOR_RESET: assert property (@(posedge sys_clk) disable iff (rst) // [RULE8]
      $past(rst) |-> range_floor == IRR_RST_FLOOR)
      else $error("range floor reset value wrong");
   AST_READY_FLAG: assert property (@(posedge sys_clk) disable iff (rst) // [RULE10]
      sample_done |=> data_ready ##0 (capture || sample_done || data_ready) [*1])
      else $error("ready flag not set by a new sample");
   AST_READY_CLEAR: assert property (@(posedge sys_clk) disable iff (rst) // [RULE10]
      capture && !sample_done |=> !data_ready)
      else $error("ready flag not cleared by the snapshot read");
endmodule // irr_readout
`default_nettype wire

// ==== verif/irr_host_model.sv ====
// host-side spi master model that reads and writes the readout registers
`timescale 1ns/1ps
`default_nettype none
module irr_host_model (
   input  wire logic sys_clk,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_sdi,
   input  wire logic spi_sdo,
   input  wire logic spi_sdo_oe
);
   logic       flip;
   logic       miso;
   logic [7:0] rd_buf [0:15];
   initial begin
      flip     = 1'b0;
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b0;
   end
   always @(posedge sys_clk) begin
      flip <= ~flip;
   end
   // a released data line holds no value: toggle it so a stale bit cannot match
   assign miso = spi_sdo_oe ? spi_sdo : flip;
   // ****************************************
   // byte transfer, mode 0, msb first
   // ****************************************
   // 10-cycle phases stay above the 5-cycle minimum of the pin synchronisers
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_sdi <= tx[i];
         repeat (10) @(posedge sys_clk);
         spi_sclk <= 1'b1;
         rx[i] = miso;
         repeat (10) @(posedge sys_clk);
         spi_sclk <= 1'b0;
      end
   endtask
   // one framed access: command byte, then n data bytes with auto-increment
   task automatic access(input logic rw, input logic [6:0] addr, input int n,
                         input logic [7:0] wb);
      logic [7:0] cmd_echo;
      @(posedge sys_clk);
      spi_cs_n <= 1'b0;
      xfer({rw, addr}, cmd_echo);
      for (int k = 0; k < n; k++) begin
         xfer(wb, rd_buf[k]);
      end
      repeat (10) @(posedge sys_clk);
      spi_cs_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
   endtask
endmodule // irr_host_model
`default_nettype wire

// ==== verif/tb_inductive_result_readout.sv ====
// self-checking testbench of the inductive result readout
`timescale 1ns/1ps
`default_nettype none
module tb_inductive_result_readout;
   import irr_pkg::*;
   localparam int OSC_HALF = 10;
   logic        sys_clk       = 1'b0;
   logic        rst           = 1'b1;
   logic        sensor_osc    = 1'b0;
   logic [15:0] impedance_raw = 16'h0000;
   logic [31:0] lfsr_state    = 32'h5c7c0569;
   logic        spi_sclk;
   logic        spi_cs_n;
   logic        spi_sdi;
   logic        spi_sdo;
   logic        spi_sdo_oe;
   int          n_mismatch    = 0;
   int          check_count   = 0;
   irr_readout irr_readout_i (.sys_clk, .rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
                              .spi_sdo_oe, .sensor_osc, .impedance_raw);
   irr_host_model irr_host_model_i (.sys_clk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
                                    .spi_sdo_oe);
   always #5 sys_clk = ~sys_clk;
   always begin
      repeat (OSC_HALF) @(posedge sys_clk);
      sensor_osc <= ~sensor_osc;
   end
   // ****************************************
   // expectation helpers
   // ****************************************
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] clip(input logic [15:0] raw, input logic [4:0] fl,
                                        input logic [4:0] cl);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = {~fl, 11'h000};
      hi = {~cl, IRR_LIMIT_FILL};
      return (raw < lo) ? lo : ((raw > hi) ? hi : raw);
   endfunction
   // sys_clk cycles in one sample window; codes below the minimum act as the minimum
   function automatic int window(input logic [2:0] code);
      int c;
      c = (code < IRR_RESP_CODE_MIN) ? int'(IRR_RESP_CODE_MIN) : int'(code);
      return ((int'(IRR_RESP_BASE) << (c - 2)) / int'(IRR_RESP_DIVISOR)) * 2 * OSC_HALF;
   endfunction
   function automatic logic [7:0] rb(input int k);
      return irr_host_model_i.rd_buf[k];
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      // a clean run needs about 83000 cycles
      repeat (95000) @(posedge sys_clk);
      n_mismatch++;
      end_of_test();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [2:0]  codes [0:2];
      logic [15:0] corner [0:2];
      logic [7:0]  prev [0:5];
      logic [15:0] prox;
      logic [23:0] f24;
      int          w;
      codes  = '{3'h0, 3'h3, 3'h4};
      corner = '{16'h0000, 16'hffff, 16'h0000};
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (10) @(posedge sys_clk);
      irr_host_model_i.access(1'b1, IRR_ADDR_STATUS, 6, 8'h00);
      check(rb(0), 8'h40, "status after reset");
      for (int k = 1; k < 6; k++) begin
         check(rb(k), 8'h00, "result after reset");
      end
      // unmapped places in this burst must read as zero
      irr_host_model_i.access(1'b1, IRR_ADDR_CEILING, 11, 8'h00);
      for (int k = 0; k < 11; k++) begin
         check(rb(k), (k == 0) ? IRR_RST_CEILING : ((k == 1) ? 8'h14 : 8'h00),
               "reset reg");
      end
      $display("test reset values done at %0t", $time);
      irr_host_model_i.access(1'b0, IRR_ADDR_FLOOR, 1, 8'h18);
      irr_host_model_i.access(1'b0, IRR_ADDR_CEILING, 1, 8'h06);
      irr_host_model_i.access(1'b0, IRR_ADDR_POWER, 1, 8'h01);
      for (int i = 0; i < 3; i++) begin
         lfsr_state = lfsr_next(lfsr_state);
         impedance_raw <= (i == 2) ? lfsr_state[15:0] : corner[i];
         irr_host_model_i.access(1'b0, IRR_ADDR_CONFIG, 1, {5'h00, codes[i]});
         w = window(codes[i]);
         repeat (3 * w) @(posedge sys_clk);
         irr_host_model_i.access(1'b1, IRR_ADDR_STATUS, 6, 8'h00);
         check(rb(0), 8'h00, "status ready");
         prox = clip(impedance_raw, 5'h18, 5'h06);
         check(rb(1), prox[7:0], "proximity low");
         check(rb(2), prox[15:8], "proximity high");
         f24 = {rb(5), rb(4), rb(3)};
         check_count++;
         if (((f24 >= w - 2 * OSC_HALF) && (f24 <= w + 2 * OSC_HALF)) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: frequency count %h window %0d", $time, f24, w);
         end
         for (int k = 0; k < 6; k++) begin
            prev[k] = rb(k);
         end
         impedance_raw <= ~impedance_raw;
         repeat (3 * w) @(posedge sys_clk);
         // later bytes alone must not refresh the held snapshot
         irr_host_model_i.access(1'b1, IRR_ADDR_PROX_HI, 4, 8'h00);
         for (int k = 0; k < 4; k++) begin
            check(rb(k), prev[k + 2], "held snapshot");
         end
         $display("test code %0d done at %0t", codes[i], $time);
      end
      irr_host_model_i.access(1'b0, IRR_ADDR_POWER, 1, 8'h00);
      irr_host_model_i.access(1'b1, IRR_ADDR_STATUS, 6, 8'h00);
      for (int k = 0; k < 6; k++) begin
         prev[k] = rb(k);
      end
      impedance_raw <= 16'h8000;
      repeat (3 * window(3'h4)) @(posedge sys_clk);
      irr_host_model_i.access(1'b1, IRR_ADDR_STATUS, 6, 8'h00);
      check(rb(0), 8'h40, "no data in standby");
      check(rb(1), prev[1], "standby proximity low");
      check(rb(2), prev[2], "standby proximity high");
      $display("test standby done at %0t", $time);
      end_of_test();
   end
endmodule // tb_inductive_result_readout
`default_nettype wire
